// file: src/sscl_pkg.sv
// package: field layout, latch selects and ranges for the serial config latches
package sscl_pkg;
  localparam int WORD_W      = 32;
  localparam int SEL_W       = 3;
  localparam int SEL_MSB     = 2;
  localparam int SEL_LSB     = 0;
  localparam logic [2:0] SEL_MAIN = 3'h0;
  localparam logic [2:0] SEL_FINE = 3'h1;
  localparam logic [2:0] SEL_REF  = 3'h2;
  localparam int NUM_LATCH   = 8;
  // main divider word
  localparam int RAMP_BIT    = 31;
  localparam int OBS_MSB     = 30;
  localparam int OBS_LSB     = 27;
  localparam int INT_MSB     = 26;
  localparam int INT_LSB     = 15;
  localparam int FHI_MSB     = 14;
  localparam int FHI_LSB     = 3;
  // fine lsb / phase word
  localparam int PADJ_BIT    = 28;
  localparam int FLO_MSB     = 27;
  localparam int FLO_LSB     = 15;
  localparam int PH_MSB      = 14;
  localparam int PH_LSB      = 3;
  // reference / pump word
  localparam int SLIP_BIT    = 28;
  localparam int PUMP_MSB    = 27;
  localparam int PUMP_LSB    = 24;
  localparam int PRE_BIT     = 22;
  localparam int HALF_BIT    = 21;
  localparam int DBL_BIT     = 20;
  localparam int RC_MSB      = 19;
  localparam int RC_LSB      = 15;
  localparam int CK1_MSB     = 14;
  localparam int CK1_LSB     = 3;
  // ranges
  localparam logic [11:0] INT_MIN = 12'h017;
  localparam logic [11:0] INT_MAX = 12'hfff;
  localparam logic [4:0]  RC_ZERO = 5'h00;
  localparam logic [5:0]  RC_FULL = 6'h20;

  typedef struct packed {
    logic        ramp_on;
    logic [3:0]  observe_select;
    logic [11:0] int_value;
    logic [24:0] fine_numerator;
    logic        phase_adjust_en;
    logic [11:0] phase_value;
  } sscl_main_t;

  typedef struct packed {
    logic        cycle_slip_reduction;
    logic [3:0]  pump_current_code;
    logic        prescaler_sel;
    logic        ref_halver;
    logic        ref_doubler;
    logic [5:0]  ref_divide;
    logic [11:0] ramp_clk1_div;
  } sscl_ref_t;
endpackage

// file: src/sscl_latches.sv
// serial shift register, eight config latches and staged commit on main word write
`timescale 1ns/10ps
`default_nettype none
module sscl_latches
  import sscl_pkg::*;
(
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset,
  input  wire logic               i_serial_clk,
  input  wire logic               i_serial_data,
  input  wire logic               i_load_latch_strobe,
  output var  logic [WORD_W-1:0]  o_latch_word [NUM_LATCH],
  output var  sscl_main_t         o_main,
  output var  sscl_ref_t          o_ref,
  output var  logic               o_int_valid,
  output var  logic               o_load_pulse
);

  // edge detect history, shift register and load pulse
  logic              sclk_d_r;
  logic              sclk_d_nxt;
  logic              strobe_d_r;
  logic              strobe_d_nxt;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;
  logic              load_r;
  logic              load_nxt;
  logic [WORD_W-1:0] latch_r [NUM_LATCH];

  // staged parts of latches one and two
  logic [12:0]       staged_flo_r;
  logic [12:0]       staged_flo_nxt;
  logic              staged_padj_r;
  logic              staged_padj_nxt;
  logic [11:0]       staged_ph_r;
  logic [11:0]       staged_ph_nxt;
  sscl_ref_t         staged_ref_r;
  sscl_ref_t         staged_ref_nxt;

  // active settings
  sscl_main_t        main_r;
  sscl_main_t        main_nxt;
  sscl_ref_t         ref_r;
  sscl_ref_t         ref_nxt;
  logic              int_valid_r;
  logic              int_valid_nxt;

  // strobe and latch select decode
  logic              sclk_rise;
  logic              strobe_rise;
  logic [SEL_W-1:0]  sel;
  logic              wr_main;
  logic              wr_fine;
  logic              wr_ref;

  // field slices of the shift register
  logic              ramp_field;
  logic [3:0]        obs_field;
  logic [11:0]       int_field;
  logic [11:0]       fhi_field;
  logic              int_ok;
  logic [12:0]       flo_field;
  logic              padj_field;
  logic [11:0]       ph_field;
  logic              slip_field;
  logic [3:0]        pump_field;
  logic              pre_field;
  logic              half_field;
  logic              dbl_field;
  logic [4:0]        rc_field;
  logic [5:0]        rc_ratio;
  logic [11:0]       ck1_field;
  sscl_ref_t         ref_dec;
  sscl_main_t        main_dec;

  assign sclk_rise   = i_serial_clk & ~sclk_d_r;
  assign strobe_rise = i_load_latch_strobe & ~strobe_d_r;
  assign sel         = shift_r[SEL_MSB:SEL_LSB];
  assign wr_main     = strobe_rise && (sel == SEL_MAIN);
  assign wr_fine     = strobe_rise && (sel == SEL_FINE);
  assign wr_ref      = strobe_rise && (sel == SEL_REF);

  // main divider word
  assign ramp_field = shift_r[RAMP_BIT];
  assign obs_field  = shift_r[OBS_MSB:OBS_LSB];
  assign int_field  = shift_r[INT_MSB:INT_LSB];
  assign fhi_field  = shift_r[FHI_MSB:FHI_LSB];
  assign int_ok     = (int_field >= INT_MIN) && (int_field <= INT_MAX);

  // fine lsb / phase word
  assign padj_field = shift_r[PADJ_BIT];
  assign flo_field  = shift_r[FLO_MSB:FLO_LSB];
  assign ph_field   = shift_r[PH_MSB:PH_LSB];

  // reference / pump word
  assign slip_field = shift_r[SLIP_BIT];
  assign pump_field = shift_r[PUMP_MSB:PUMP_LSB];
  assign pre_field  = shift_r[PRE_BIT];
  assign half_field = shift_r[HALF_BIT];
  assign dbl_field  = shift_r[DBL_BIT];
  assign rc_field   = shift_r[RC_MSB:RC_LSB];
  assign ck1_field  = shift_r[CK1_MSB:CK1_LSB];
  // five-bit count zero means 32
  assign rc_ratio   = (rc_field == RC_ZERO) ? RC_FULL : {1'h0, rc_field};

  assign ref_dec.cycle_slip_reduction = slip_field;
  assign ref_dec.pump_current_code    = pump_field;
  assign ref_dec.prescaler_sel        = pre_field;
  assign ref_dec.ref_halver           = half_field;
  assign ref_dec.ref_doubler          = dbl_field;
  assign ref_dec.ref_divide           = rc_ratio;
  assign ref_dec.ramp_clk1_div        = ck1_field;

  // latch zero commit merges new word with staged parts
  assign main_dec.ramp_on         = ramp_field;
  assign main_dec.observe_select  = obs_field;
  // an out of range integer keeps the active one
  assign main_dec.int_value       = int_ok ? int_field : main_r.int_value;
  assign main_dec.fine_numerator  = {fhi_field, staged_flo_r};
  assign main_dec.phase_adjust_en = staged_padj_r;
  assign main_dec.phase_value     = staged_ph_r;

  // next values
  assign sclk_d_nxt      = i_serial_clk;
  assign strobe_d_nxt    = i_load_latch_strobe;
  assign load_nxt        = strobe_rise;
  assign shift_nxt       = sclk_rise ? {shift_r[WORD_W-2:0], i_serial_data} : shift_r;
  assign staged_flo_nxt  = wr_fine ? flo_field : staged_flo_r;
  assign staged_padj_nxt = wr_fine ? padj_field : staged_padj_r;
  assign staged_ph_nxt   = wr_fine ? ph_field : staged_ph_r;
  assign staged_ref_nxt  = wr_ref ? ref_dec : staged_ref_r;
  assign main_nxt        = wr_main ? main_dec : main_r;
  assign ref_nxt         = wr_main ? staged_ref_r : ref_r;
  assign int_valid_nxt   = wr_main ? int_ok : int_valid_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      sclk_d_r <= '0;
    end
    else
    begin
      sclk_d_r <= sclk_d_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      strobe_d_r <= '0;
    end
    else
    begin
      strobe_d_r <= strobe_d_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      shift_r <= '0;
    end
    else
    begin
      shift_r <= shift_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      load_r <= '0;
    end
    else
    begin
      load_r <= load_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      staged_flo_r <= '0;
    end
    else
    begin
      staged_flo_r <= staged_flo_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      staged_padj_r <= '0;
    end
    else
    begin
      staged_padj_r <= staged_padj_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      staged_ph_r <= '0;
    end
    else
    begin
      staged_ph_r <= staged_ph_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      staged_ref_r <= '0;
    end
    else
    begin
      staged_ref_r <= staged_ref_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      main_r <= '0;
    end
    else
    begin
      main_r <= main_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      ref_r <= '0;
    end
    else
    begin
      ref_r <= ref_nxt;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      int_valid_r <= '0;
    end
    else
    begin
      int_valid_r <= int_valid_nxt;
    end
  end

  // one latch per select value
  genvar g;
  generate
    for (g = 0; g < NUM_LATCH; g++)
    begin : g_latch
      wire hit = strobe_rise && (sel == SEL_W'(g));
      always_ff @(posedge i_sys_clk)
      begin
        if (i_reset)
        begin
          latch_r[g] <= '0;
        end
        else if (hit)
        begin
          latch_r[g] <= shift_r;
        end
      end
      assign o_latch_word[g] = latch_r[g];
    end
  endgenerate

  assign o_main       = main_r;
  assign o_ref        = ref_r;
  assign o_int_valid  = int_valid_r;
  assign o_load_pulse = load_r;

endmodule
`default_nettype wire

// file: verif/sscl_checker.sv
// checker: port relations of the config latches
`timescale 1ns/10ps
`default_nettype none
module sscl_checker
  import sscl_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_reset,
  input wire logic              i_serial_clk,
  input wire logic              i_serial_data,
  input wire logic              i_load_latch_strobe,
  input wire logic [WORD_W-1:0] o_latch_word [NUM_LATCH],
  input wire sscl_main_t        o_main,
  input wire sscl_ref_t         o_ref,
  input wire logic              o_int_valid,
  input wire logic              o_load_pulse
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  AST_LOAD: assert property ($rose(i_load_latch_strobe) |=> o_load_pulse ##1 !o_load_pulse) else $error("load");
  AST_QUIET: assert property (!$rose(i_load_latch_strobe) |=> !o_load_pulse) else $error("stray");
  AST_HOLD: assert property (!o_load_pulse |-> $stable(o_latch_word[1]) && $stable(o_main)) else $error("hold");
  AST_FINE: assert property ($changed(o_main) |->
    o_main.fine_numerator == {o_latch_word[0][14:3], o_latch_word[1][27:15]}) else $error("fine");
  AST_MODE: assert property ($changed(o_main) |->
    {o_main.ramp_on, o_main.observe_select} == o_latch_word[0][31:27]) else $error("mode");
  AST_REF: assert property ($changed(o_ref) |-> o_ref.pump_current_code == o_latch_word[2][27:24]) else $error("ref");
  AST_INT: assert property (o_int_valid |-> o_main.int_value >= 12'h017) else $error("int");
  AST_RC: assert property (o_ref.ref_divide != 6'h00 |-> o_ref.ref_divide <= 6'h20) else $error("ratio");
  AST_RC_MAP: assert property ($changed(o_ref) |->
    o_ref.ref_divide != 6'h00 && o_ref.ref_divide[4:0] == o_latch_word[2][RC_MSB:RC_LSB]) else $error("rmap");
  AST_PHASE: assert property ($changed(o_main) |->
    {o_main.phase_adjust_en, o_main.phase_value} == {o_latch_word[1][PADJ_BIT], o_latch_word[1][PH_MSB:PH_LSB]})
    else $error("phase");
  AST_INT_TAKE: assert property ($changed(o_main) && o_int_valid |->
    o_main.int_value == o_latch_word[0][INT_MSB:INT_LSB]) else $error("itake");
  AST_INT_KEEP: assert property ($changed(o_main) && !o_int_valid |->
    o_main.int_value == $past(o_main.int_value)) else $error("ikeep");
endmodule
bind sscl_latches sscl_checker u_chk (
  .i_sys_clk           (i_sys_clk),
  .i_reset             (i_reset),
  .i_serial_clk        (i_serial_clk),
  .i_serial_data       (i_serial_data),
  .i_load_latch_strobe (i_load_latch_strobe),
  .o_latch_word        (o_latch_word),
  .o_main              (o_main),
  .o_ref               (o_ref),
  .o_int_valid         (o_int_valid),
  .o_load_pulse        (o_load_pulse)
);
`default_nettype wire

// file: verif/sscl_host.sv
// host model: shifts words msb first, then pulses the load strobe
`timescale 1ns/10ps
`default_nettype none
module sscl_host (
  input  wire logic i_sys_clk,
  output var  logic o_serial_clk,
  output var  logic o_serial_data,
  output var  logic o_load_latch_strobe
);
  initial {o_serial_clk, o_serial_data, o_load_latch_strobe} = 3'h0;
  // callers keep reserved bits zero
  task automatic send(input logic [31:0] w);
    for (int i = 63; i >= -3; i--)
    begin
      o_serial_clk = i >= 0 && !i[0];
      o_serial_data = i >= 0 ? w[i/2] : ~w[0];
      o_load_latch_strobe = i == -2;
      repeat (2) @(negedge i_sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: verif/synth_serial_config_latches_tb.sv
// testbench: staged commit, integer range and latch select
`timescale 1ns/10ps
`default_nettype none
module synth_serial_config_latches_tb;
  import sscl_pkg::*;
  logic              clk = 1'b0, rst = 1'b1, sclk, sdat, stb, iv, lp;
  logic [WORD_W-1:0] lw [NUM_LATCH];
  sscl_main_t        m;
  sscl_ref_t         r;
  int                n_fail = 0, samples_checked = 0, n_load = 0;
  sscl_host host (.i_sys_clk(clk), .o_serial_clk(sclk), .o_serial_data(sdat), .o_load_latch_strobe(stb));
  sscl_latches dut (.i_sys_clk(clk), .i_reset(rst), .i_serial_clk(sclk), .i_serial_data(sdat),
    .i_load_latch_strobe(stb), .o_latch_word(lw), .o_main(m), .o_ref(r), .o_int_valid(iv), .o_load_pulse(lp));
  initial forever #2 clk = ~clk;
  // load pulses counted away from the launching edge
  always @(negedge clk) n_load += int'(lp === 1'b1);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    n_fail += int'(got !== exp);
    if (got !== exp) $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic stop_test(input int extra);
    n_fail += extra;
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_stage;
    host.send({3'h0, 1'b1, 13'h1abc, 12'h234, 3'h1});
    chk(lw[1], {3'h0, 1'b1, 13'h1abc, 12'h234, 3'h1});
    chk(m, 64'h0);
    host.send({1'b1, 4'h9, 12'h064, 12'h5a5, 3'h0});
    chk(m, {1'b1, 4'h9, 12'h064, 12'h5a5, 13'h1abc, 1'b1, 12'h234});
    chk(lw[0], {1'b1, 4'h9, 12'h064, 12'h5a5, 3'h0});
  endtask
  task automatic t_ref;
    host.send({3'h0, 1'b1, 4'hc, 1'b0, 1'b1, 1'b1, 1'b0, 5'h00, 12'h0f3, 3'h2});
    chk(r, 64'h0);
    chk(lw[2], {3'h0, 1'b1, 4'hc, 1'b0, 1'b1, 1'b1, 1'b0, 5'h00, 12'h0f3, 3'h2});
    host.send({17'h00016, 12'h000, 3'h0});
    chk({iv, m.int_value}, {1'b0, 12'h064});
    host.send({17'h00017, 12'h000, 3'h0});
    chk({iv, r}, {1'b1, 1'b1, 4'hc, 1'b1, 1'b1, 1'b0, 6'h20, 12'h0f3});
  endtask
  task automatic t_sel;
    int n0;
    n0 = n_load;
    for (int s = 3; s < NUM_LATCH; s++)
    begin
      host.send({16'(s * 16'h1234), 13'h0, 3'(s)});
      chk(lw[s], {16'(s * 16'h1234), 13'h0, 3'(s)});
    end
    chk(lw[3], {16'(3 * 16'h1234), 13'h0, 3'h3});
    chk(n_load - n0, 5);
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_stage();
    t_ref();
    t_sel();
    stop_test(0);
  end
  initial #20000 stop_test(1);
endmodule
`default_nettype wire
